// ### mc_cfg.svh
`ifndef MC_CFG_SVH
`define MC_CFG_SVH

// Management register addresses
`define MC_ADDR_STATUS     5'h1B
`define MC_ADDR_TEST       5'h1C

// Test-control field positions
`define MC_TC_EDGE_ALT     4
`define MC_TC_FSENSE_OFF   3
`define MC_TC_FARFLT_OFF   2
`define MC_TC_BACKUP_OFF   1
`define MC_TC_RESET        16'h0000

// Status field positions
`define MC_ST_F_LOCAL_OSC  15
`define MC_ST_F_FREQ_ERR   14
`define MC_ST_FAR_FAULT    13
`define MC_ST_C_LOCAL_OSC  12
`define MC_ST_C_FREQ_ERR   11
`define MC_ST_SEED_LOST    10
`define MC_ST_LINK_UP      9
`define MC_ST_NEG_DONE     8
`define MC_ST_C_FAST       7
`define MC_ST_C_SLOW       6
`define MC_ST_C_PACKET     5
`define MC_ST_C_BURST      4
`define MC_ST_F_FAST       3
`define MC_ST_F_SLOW       2
`define MC_ST_F_PACKET     1
`define MC_ST_F_BURST      0

// Management frame fields
`define MC_PRE_ONES        6'h20
`define MC_START           2'h1
`define MC_OP_READ         2'h2
`define MC_OP_WRITE        2'h1
`define MC_HDR_LAST        4'hD
`define MC_DATA_LAST       4'hF

// Timing
`define MC_CLK_MHZ         10
`define MC_SEED_LOSS_US    1300

`endif

// ### mc_pkg.sv
package mc_pkg;

	typedef enum logic [1:0] {
		MC_PRE  = 2'h0,
		MC_HDR  = 2'h1,
		MC_TA   = 2'h3,
		MC_DATA = 2'h2
	} mc_state_t;

	typedef struct packed {
		logic pll_on_local_osc;
		logic pll_freq_error;
		logic far_fault_seen;
		logic rx_fast_detect;
		logic rx_slow_detect;
		logic packet_seen;
		logic negotiation_burst;
	} mc_fiber_t;

	typedef struct packed {
		logic pll_on_local_osc;
		logic pll_freq_error;
		logic link_up;
		logic negotiation_done;
		logic rx_fast_detect;
		logic rx_slow_detect;
		logic packet_seen;
		logic flp_burst;
		logic fiber_burst;
	} mc_copper_t;

	typedef struct packed {
		logic       mdc;
		logic       mdio;
		logic [4:0] phy_addr;
		mc_fiber_t  fiber;
		mc_copper_t copper;
		logic       filter_reset;
		logic       backup_pin;
	} mc_pins_t;

endpackage : mc_pkg

// ### mc_test_status_regs.sv
// Notes on behaviour
// - Test register 0x1C fully read/write, resets zero
// - Bit 4 selects alternate transmit edge rate
// - Bit 3 turns off PLL frequency sensing
// - Bit 2 stops far-end-fault generation and detection
// - Bit 1 disables backup link over pin
// - Status register 0x1B ignores all writes
// - Bit 15: fiber PLL on local oscillator
// - Bit 14: fiber PLL frequency out of window
// - Frequency flags held off when sensing off
// - Bit 13: far-end-fault pattern seen on fiber
// - Bit 12: copper PLL on local oscillator
// - Bit 11: copper PLL frequency out of window
// - Bit 10: seed loss latched until read or seed update
// - Bit 9: link up, latched low, non-transparent
// - Bit 8: negotiation done, non-transparent only
// - Bits 7,6: copper 100/10 signal detected
// - Bit 5: copper packet latched, gated by detect
// - Bit 4: copper bursts, fiber bursts in PECL
// - Bits 3,2: fiber 100/10 signal detected
// - Bit 1: fiber packet latched, gated by detect
// - Bit 0: fiber negotiation bursts detected
// - Mode bit: one means non-transparent
// - Scrambler enable qualifies seed loss
// - PECL mode changes burst bit meaning
`timescale 1ns/1ps
`include "mc_cfg.svh"

module mc_test_status_regs
	import mc_pkg::*;
#(
	parameter int unsigned SEED_CYC = `MC_SEED_LOSS_US * `MC_CLK_MHZ
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_mdc,
	input  wire logic       i_mdio,
	output logic            o_mdio,
	output logic            o_mdio_oe,
	input  wire logic [4:0] i_phy_addr,
	input  wire mc_fiber_t  i_fiber,
	input  wire mc_copper_t i_copper,
	input  wire logic       i_pll_filter_reset,
	input  wire logic       i_backup_path_pin,
	input  wire logic       i_non_transparent,
	input  wire logic       i_scrambler_enable,
	input  wire logic       i_copper_port_pecl_mode,
	input  wire logic       i_seed_update,
	output logic            o_tx_edge_rate_alt,
	output logic            o_freq_sense_off,
	output logic            o_far_fault_off,
	output logic            o_backup_path_en
);

	localparam logic [15:0] SEED_LAST = 16'(SEED_CYC - 1);
	// Reset release
	logic rst_meta, rst_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pin synchronisers
	mc_pins_t pins_in, pins_meta, pins;

	always_comb begin
		pins_in.mdc          = i_mdc;
		pins_in.mdio         = i_mdio;
		pins_in.phy_addr     = i_phy_addr;
		pins_in.fiber        = i_fiber;
		pins_in.copper       = i_copper;
		pins_in.filter_reset = i_pll_filter_reset;
		pins_in.backup_pin   = i_backup_path_pin;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_meta <= '0;
			pins      <= '0;
		end else if (i_ce) begin
			pins_meta <= pins_in;
			pins      <= pins_meta;
		end
	end

	// Management frame engine
	mc_state_t   state, next_state;
	logic [5:0]  ones, next_ones;
	logic [3:0]  cnt, next_cnt;
	logic [12:0] hdr, next_hdr;
	logic [15:0] dsh, next_dsh;
	logic        is_read, next_is_read;
	logic [4:0]  reg_addr, next_reg_addr;
	logic        mdc_d, next_mdc_d;
	logic        mdio_o, next_mdio_o;
	logic        mdio_oe, next_mdio_oe;
	logic        commit, next_commit;
	logic        rd_done, next_rd_done;
	logic [15:0] test_ctrl, next_test_ctrl;
	logic [15:0] status;
	logic [13:0] word;
	logic        rise, bit_in;

	always_comb begin
		next_state     = state;
		next_ones      = ones;
		next_cnt       = cnt;
		next_hdr       = hdr;
		next_dsh       = dsh;
		next_is_read   = is_read;
		next_reg_addr  = reg_addr;
		next_mdc_d     = pins.mdc;
		next_mdio_o    = mdio_o;
		next_mdio_oe   = mdio_oe;
		next_commit    = 1'b0;
		next_rd_done   = 1'b0;
		next_test_ctrl = test_ctrl;
		rise           = pins.mdc & ~mdc_d;
		bit_in         = pins.mdio;
		word           = {hdr, bit_in};
		if (commit && reg_addr == `MC_ADDR_TEST) begin
			next_test_ctrl = dsh;
		end
		if (rise) begin
			case (state)
				MC_PRE: begin
					if (bit_in) begin
						if (ones != `MC_PRE_ONES)
							next_ones = ones + 6'h01;
					end else if (ones == `MC_PRE_ONES) begin
						next_state = MC_HDR;
						next_hdr   = 13'h0000;
						next_cnt   = 4'h1;
					end else begin
						next_ones = 6'h00;
					end
				end
				MC_HDR: begin
					next_hdr = word[12:0];
					next_cnt = cnt + 4'h1;
					if (cnt == `MC_HDR_LAST) begin
						next_cnt      = 4'h0;
						next_reg_addr = word[4:0];
						next_is_read  = word[11:10] == `MC_OP_READ;
						if (word[13:12] == `MC_START &&
						    (word[11:10] == `MC_OP_READ ||
						     word[11:10] == `MC_OP_WRITE) &&
						    word[9:5] == pins.phy_addr) begin
							next_state = MC_TA;
						end else begin
							next_state = MC_PRE;
							next_ones  = 6'h00;
						end
					end
				end
				MC_TA: begin
					next_cnt = cnt + 4'h1;
					if (cnt == 4'h0) begin
						next_mdio_oe = is_read;
						next_mdio_o  = 1'b0;
					end else begin
						next_state = MC_DATA;
						next_cnt   = 4'h0;
						case (reg_addr)
							`MC_ADDR_STATUS: next_dsh = status;
							`MC_ADDR_TEST:   next_dsh = test_ctrl;
							default:         next_dsh = 16'h0000;
						endcase
						next_mdio_o = is_read & next_dsh[15];
					end
				end
				MC_DATA: begin
					next_cnt    = cnt + 4'h1;
					next_dsh    = {dsh[14:0], bit_in};
					next_mdio_o = is_read & dsh[14];
					if (cnt == `MC_DATA_LAST) begin
						next_state   = MC_PRE;
						next_ones    = 6'h00;
						next_mdio_oe = 1'b0;
						next_mdio_o  = 1'b0;
						next_commit  = ~is_read;
						next_rd_done = is_read &&
						    reg_addr == `MC_ADDR_STATUS;
					end
				end
				default: begin
					next_state = MC_PRE;
					next_ones  = 6'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= MC_PRE;
			ones      <= 6'h00;
			cnt       <= 4'h0;
			hdr       <= 13'h0000;
			dsh       <= 16'h0000;
			is_read   <= 1'b0;
			reg_addr  <= 5'h00;
			mdc_d     <= 1'b0;
			mdio_o    <= 1'b0;
			mdio_oe   <= 1'b0;
			commit    <= 1'b0;
			rd_done   <= 1'b0;
			test_ctrl <= `MC_TC_RESET;
		end else if (i_ce) begin
			state     <= next_state;
			ones      <= next_ones;
			cnt       <= next_cnt;
			hdr       <= next_hdr;
			dsh       <= next_dsh;
			is_read   <= next_is_read;
			reg_addr  <= next_reg_addr;
			mdc_d     <= next_mdc_d;
			mdio_o    <= next_mdio_o;
			mdio_oe   <= next_mdio_oe;
			commit    <= next_commit;
			rd_done   <= next_rd_done;
			test_ctrl <= next_test_ctrl;
		end
	end

	// Status latches and live word
	logic [15:0] seed_cnt, next_seed_cnt;
	logic        seed_lost, next_seed_lost;
	logic        link_drop, next_link_drop;
	logic        c_pkt, next_c_pkt;
	logic        f_pkt, next_f_pkt;
	logic        fs_gate, c_det, f_det, expired;

	always_comb begin
		fs_gate = test_ctrl[`MC_TC_FSENSE_OFF] | pins.filter_reset;
		c_det   = pins.copper.rx_fast_detect | pins.copper.rx_slow_detect;
		f_det   = pins.fiber.rx_fast_detect | pins.fiber.rx_slow_detect;
		expired = seed_cnt == SEED_LAST;
		next_seed_cnt = seed_cnt;
		if (!i_scrambler_enable || i_seed_update)
			next_seed_cnt = 16'h0000;
		else if (!expired)
			next_seed_cnt = seed_cnt + 16'h0001;
		next_seed_lost = (seed_lost & ~rd_done & ~i_seed_update) |
		    (i_scrambler_enable & expired);
		next_link_drop = (link_drop & ~rd_done) |
		    ~pins.copper.link_up;
		next_c_pkt = ((c_pkt & ~rd_done) | pins.copper.packet_seen) &
		    c_det;
		next_f_pkt = ((f_pkt & ~rd_done) | pins.fiber.packet_seen) &
		    f_det;
		status = 16'h0000;
		status[`MC_ST_F_LOCAL_OSC] = pins.fiber.pll_on_local_osc;
		status[`MC_ST_F_FREQ_ERR]  = pins.fiber.pll_freq_error &
		    ~fs_gate;
		status[`MC_ST_FAR_FAULT]   = pins.fiber.far_fault_seen &
		    ~test_ctrl[`MC_TC_FARFLT_OFF];
		status[`MC_ST_C_LOCAL_OSC] = pins.copper.pll_on_local_osc;
		status[`MC_ST_C_FREQ_ERR]  = pins.copper.pll_freq_error &
		    ~fs_gate;
		status[`MC_ST_SEED_LOST]   = seed_lost;
		status[`MC_ST_LINK_UP]     = i_non_transparent &
		    pins.copper.link_up & ~link_drop;
		status[`MC_ST_NEG_DONE]    = i_non_transparent &
		    pins.copper.negotiation_done;
		status[`MC_ST_C_FAST]      = pins.copper.rx_fast_detect;
		status[`MC_ST_C_SLOW]      = pins.copper.rx_slow_detect;
		status[`MC_ST_C_PACKET]    = c_pkt & c_det;
		status[`MC_ST_C_BURST]     = pins.copper.flp_burst |
		    (i_copper_port_pecl_mode &
		     pins.copper.fiber_burst);
		status[`MC_ST_F_FAST]      = pins.fiber.rx_fast_detect;
		status[`MC_ST_F_SLOW]      = pins.fiber.rx_slow_detect;
		status[`MC_ST_F_PACKET]    = f_pkt & f_det;
		status[`MC_ST_F_BURST]     = pins.fiber.negotiation_burst;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			seed_cnt  <= 16'h0000;
			seed_lost <= 1'b0;
			link_drop <= 1'b0;
			c_pkt     <= 1'b0;
			f_pkt     <= 1'b0;
		end else if (i_ce) begin
			seed_cnt  <= next_seed_cnt;
			seed_lost <= next_seed_lost;
			link_drop <= next_link_drop;
			c_pkt     <= next_c_pkt;
			f_pkt     <= next_f_pkt;
		end
	end

	// Registered outputs
	logic next_edge, next_fsense, next_farflt, next_backup;

	always_comb begin
		next_edge   = test_ctrl[`MC_TC_EDGE_ALT];
		next_fsense = test_ctrl[`MC_TC_FSENSE_OFF];
		next_farflt = test_ctrl[`MC_TC_FARFLT_OFF];
		next_backup = pins.backup_pin &
		    ~test_ctrl[`MC_TC_BACKUP_OFF];
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_tx_edge_rate_alt <= 1'b0;
			o_freq_sense_off   <= 1'b0;
			o_far_fault_off    <= 1'b0;
			o_backup_path_en   <= 1'b0;
			o_mdio             <= 1'b0;
			o_mdio_oe          <= 1'b0;
		end else if (i_ce) begin
			o_tx_edge_rate_alt <= next_edge;
			o_freq_sense_off   <= next_fsense;
			o_far_fault_off    <= next_farflt;
			o_backup_path_en   <= next_backup;
			o_mdio             <= mdio_o;
			o_mdio_oe          <= mdio_oe;
		end
	end

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	chk_test_write: assert property (
		(i_ce && commit && reg_addr == `MC_ADDR_TEST) |=>
		    test_ctrl == $past(dsh))
		else $error("test register write not stored");
	chk_status_ro: assert property (
		(i_ce && commit && reg_addr == `MC_ADDR_STATUS) |=>
		    test_ctrl == $past(test_ctrl))
		else $error("status write changed test register");
	chk_edge_out: assert property (
		i_ce |=> o_tx_edge_rate_alt == $past(test_ctrl[`MC_TC_EDGE_ALT]))
		else $error("edge rate output wrong");
	chk_freq_gate: assert property (
		fs_gate |-> !status[`MC_ST_F_FREQ_ERR] &&
		    !status[`MC_ST_C_FREQ_ERR])
		else $error("frequency flag not held off");
	chk_far_gate: assert property (
		test_ctrl[`MC_TC_FARFLT_OFF] |-> !status[`MC_ST_FAR_FAULT])
		else $error("far fault reported while off");
	chk_backup_off: assert property (
		(i_ce && test_ctrl[`MC_TC_BACKUP_OFF]) |=> !o_backup_path_en)
		else $error("backup link not disabled");
	chk_transp_zero: assert property (
		!i_non_transparent |-> !status[`MC_ST_LINK_UP] &&
		    !status[`MC_ST_NEG_DONE])
		else $error("link bits set in transparent mode");
	chk_packet_gate: assert property (
		!c_det |-> !status[`MC_ST_C_PACKET])
		else $error("copper packet bit without detect");
	chk_seed_timeout: assert property (
		(i_ce && i_scrambler_enable && expired && !i_seed_update) ##1
		    (i_ce && i_scrambler_enable) |-> seed_lost [*2])
		else $error("seed loss not latched");

endmodule : mc_test_status_regs

// ### mc_mdio_host.sv
`timescale 1ns/1ps
`include "mc_cfg.svh"

module mc_mdio_host (
	input  wire logic i_clk,
	input  wire logic i_mdio,
	output logic      o_mdc,
	output logic      o_mdio,
	output logic      o_mdio_oe
);

	// Clocks per MDC phase, four at the least
	int half = 5;

	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_mdio_oe = 1'b0;
	end

	// One bit: drive in low phase, sample the line at the rise
	task automatic bit_cyc(input logic drv, input logic val, output logic smp);
		o_mdio_oe <= drv;
		o_mdio <= val;
		repeat (half) @(posedge i_clk);
		smp = i_mdio;
		o_mdc <= 1'b1;
		repeat (half) @(posedge i_clk);
		o_mdc <= 1'b0;
	endtask : bit_cyc

	// Whole frame; MDC stands low and the line is released after it
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic        s;
		logic        wop;
		hdr = {32'hFFFFFFFF, `MC_START, op, phy, ra};
		wop = (op != `MC_OP_READ);
		for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
		bit_cyc(wop, 1'b1, s);
		bit_cyc(wop, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(wop, wd[i], s);
			rd[i] = s;
		end
		o_mdio_oe <= 1'b0;
		o_mdio <= 1'b1;
		repeat (2 * half) @(posedge i_clk);
	endtask : frame

endmodule : mc_mdio_host

// ### media_converter_test_status_regs_bench.sv
`timescale 1ns/1ps
`include "mc_cfg.svh"

module media_converter_test_status_regs_bench
	import mc_pkg::*;
();

	localparam int SEED = 20;

	logic       clk;
	logic       rst_n;
	logic       ce;
	logic       mdio_w;
	logic       dut_mdio;
	logic       dut_oe;
	logic       h_mdc;
	logic       h_mdio;
	logic       h_oe;
	logic [4:0] phy;
	mc_fiber_t  fib;
	mc_copper_t cop;
	logic       frst;
	logic       bpin;
	logic       nt;
	logic       scr;
	logic       pecl;
	logic       supd;
	logic [3:0] pins;
	logic [15:0] lfsr;
	logic [15:0] m_tc;
	int         failures;
	int         n_checks;
	int         scnt;
	bit         cdrop;
	bit         cpkt;
	bit         fpkt;
	bit         m_seed;

	// Pulled-up management line
	assign mdio_w = dut_oe ? dut_mdio : (h_oe ? h_mdio : 1'b1);

	mc_test_status_regs #(.SEED_CYC(SEED)) dut_u (
		.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_mdc(h_mdc),
		.i_mdio(mdio_w), .o_mdio(dut_mdio), .o_mdio_oe(dut_oe),
		.i_phy_addr(phy), .i_fiber(fib), .i_copper(cop),
		.i_pll_filter_reset(frst), .i_backup_path_pin(bpin),
		.i_non_transparent(nt), .i_scrambler_enable(scr),
		.i_copper_port_pecl_mode(pecl), .i_seed_update(supd),
		.o_tx_edge_rate_alt(pins[3]), .o_freq_sense_off(pins[2]),
		.o_far_fault_off(pins[1]), .o_backup_path_en(pins[0])
	);

	mc_mdio_host host_u (
		.i_clk(clk), .i_mdio(mdio_w), .o_mdc(h_mdc),
		.o_mdio(h_mdio), .o_mdio_oe(h_oe)
	);

	always #50 clk = ~clk;

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt

	// Latch and seed-timer model
	always @(posedge clk) begin
		if (!cop.link_up) cdrop = 1'b1;
		if (cop.packet_seen) cpkt = 1'b1;
		if (!(cop.rx_fast_detect | cop.rx_slow_detect)) cpkt = 1'b0;
		if (fib.packet_seen) fpkt = 1'b1;
		if (!(fib.rx_fast_detect | fib.rx_slow_detect)) fpkt = 1'b0;
		scnt = (scr && !supd) ? scnt + 1 : 0;
		if (supd) m_seed = 1'b0;
		if (scnt >= SEED) m_seed = 1'b1;
	end

	function automatic logic [15:0] exp_st();
		logic fso;
		logic cd;
		logic fd;
		fso = m_tc[3] | frst;
		cd = cop.rx_fast_detect | cop.rx_slow_detect;
		fd = fib.rx_fast_detect | fib.rx_slow_detect;
		return {fib.pll_on_local_osc, fib.pll_freq_error & !fso,
			fib.far_fault_seen & !m_tc[2], cop.pll_on_local_osc,
			cop.pll_freq_error & !fso, m_seed | (scnt >= SEED),
			nt & cop.link_up & !cdrop, nt & cop.negotiation_done,
			cop.rx_fast_detect, cop.rx_slow_detect,
			(cpkt | cop.packet_seen) & cd,
			cop.flp_burst | (pecl & cop.fiber_burst),
			fib.rx_fast_detect, fib.rx_slow_detect,
			(fpkt | fib.packet_seen) & fd, fib.negotiation_burst};
	endfunction : exp_st

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		logic [15:0] d;
		host_u.frame(`MC_OP_WRITE, phy, a, v, d);
		if (a == `MC_ADDR_TEST) m_tc = v;
	endtask : wr

	task automatic chk(input logic [4:0] a);
		logic [15:0] e;
		logic [15:0] d;
		e = (a == `MC_ADDR_TEST) ? m_tc :
			(a == `MC_ADDR_STATUS) ? exp_st() : 16'h0000;
		host_u.frame(`MC_OP_READ, phy, a, 16'h0000, d);
		if (a == `MC_ADDR_STATUS) begin
			cdrop = 1'b0;
			cpkt = 1'b0;
			fpkt = 1'b0;
			m_seed = 1'b0;
		end
		cmp(d, e);
	endtask : chk

	task automatic pins_chk();
		cmp({12'h000, pins}, {12'h000, m_tc[4:2], bpin & !m_tc[1]});
	endtask : pins_chk

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	initial begin
		#8000000;
		failures++;
		final_report();
	end

	initial begin
		logic [15:0] w;
		logic [15:0] d;
		clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		phy = 5'h05;
		fib = '0;
		cop = '0;
		{frst, nt, scr, pecl, supd} = 5'h00;
		bpin = 1'b1;
		lfsr = 16'h0014;
		m_tc = 16'h0000;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		pins_chk();
		chk(`MC_ADDR_TEST);
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			w = (i < 5) ? (16'h0010 >> i) : (i == 7) ? 16'hFFFF : lfsr;
			bpin <= lfsr[0];
			wr(`MC_ADDR_TEST, w);
			repeat (6) @(posedge clk);
			pins_chk();
			chk(`MC_ADDR_TEST);
		end
		wr(`MC_ADDR_STATUS, 16'hFFFF);
		chk(`MC_ADDR_STATUS);
		chk(5'h00);
		host_u.frame(`MC_OP_READ, phy ^ 5'h01, `MC_ADDR_TEST, 16'h0000, d);
		cmp(d, 16'hFFFF);
		// Random live conditions, prompt and slow host
		for (int i = 0; i < 12; i++) begin
			lfsr = nxt(lfsr);
			fib <= mc_fiber_t'(lfsr[6:0]);
			cop <= mc_copper_t'(lfsr[15:7]);
			lfsr = nxt(lfsr);
			{nt, pecl, frst, scr, supd} <= lfsr[4:0];
			host_u.half = lfsr[5] ? 7 : 4;
			if (lfsr[6]) wr(`MC_ADDR_TEST, lfsr);
			repeat (30) @(posedge clk);
			pins_chk();
			chk(`MC_ADDR_STATUS);
			chk(`MC_ADDR_STATUS);
		end
		// Latched events, then release by a read
		{nt, scr, supd} <= 3'h5;
		fib <= mc_fiber_t'(7'h0A);
		cop <= mc_copper_t'(9'h054);
		repeat (6) @(posedge clk);
		chk(`MC_ADDR_STATUS);
		chk(`MC_ADDR_STATUS);
		fib <= mc_fiber_t'(7'h08);
		cop <= mc_copper_t'(9'h010);
		repeat (3) @(posedge clk);
		cop <= mc_copper_t'(9'h050);
		repeat (6) @(posedge clk);
		chk(`MC_ADDR_STATUS);
		chk(`MC_ADDR_STATUS);
		{scr, supd} <= 2'h2;
		repeat (30) @(posedge clk);
		chk(`MC_ADDR_STATUS);
		{scr, supd} <= 2'h1;
		@(posedge clk);
		supd <= 1'b0;
		repeat (6) @(posedge clk);
		chk(`MC_ADDR_STATUS);
		// Frozen by clock enable: write frame ignored
		ce <= 1'b0;
		host_u.frame(`MC_OP_WRITE, phy, `MC_ADDR_TEST, ~m_tc, d);
		ce <= 1'b1;
		chk(`MC_ADDR_TEST);
		final_report();
	end

endmodule : media_converter_test_status_regs_bench
